// >>> rtl/sscfg_pkg.sv
// Package for the strap startup configuration loader: encodings, layouts, counts.
// Assumes one 10 MHz clock; switch banks are raw pins, 1 = closed.
package sscfg_pkg;

    // ------------------------------------------------------------
    // Switch positions (bit index = position - 1)
    // ------------------------------------------------------------
    localparam int SW_BAUD_LSB = 0;
    localparam int SW_BAUD_MSB = 2;
    localparam int SW_FLOW_BIT = 3;
    localparam int SW_NET_BIT = 3;
    localparam int SW_PROT_BIT = 4;
    localparam int SW_PROTO_LSB = 5;
    localparam int SW_PROTO_MSB = 7;

    // ------------------------------------------------------------
    // Protocol and baud codes
    // ------------------------------------------------------------
    localparam logic [2:0] PROTO_SW_COMBINED = 3'h0;
    localparam logic [2:0] PROTO_SW_STRICT = 3'h1;
    localparam logic [2:0] PROTO_SW_LOOP = 3'h2;
    localparam logic [2:0] PROTO_SW_CTRL = 3'h4;
    localparam logic [2:0] BAUD_SW_9600 = 3'h0;
    localparam logic [2:0] BAUD_SW_MAX = 3'h5;

    typedef enum logic [1:0] {
        SSCFG_PR_COMBINED = 2'h0,
        SSCFG_PR_STRICT = 2'h1,
        SSCFG_PR_LOOP = 2'h2,
        SSCFG_PR_CTRL = 2'h3
    } sscfg_proto_e;

    // Port configuration carried out of the block
    typedef struct packed {
        sscfg_proto_e proto;
        logic [2:0] baud;
        logic flow_en;
        logic bad;
    } sscfg_port_s;

    // ------------------------------------------------------------
    // Startup timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 10_000_000;
    localparam int SAMPLE_US = 2;
    localparam int SAMPLE_CYC = (SAMPLE_US * CLK_HZ + 999_999) / 1_000_000;
    localparam int NETCFG_US = 10;
    localparam int NETCFG_CYC = (NETCFG_US * CLK_HZ + 999_999) / 1_000_000;

    // ------------------------------------------------------------
    // Error answer codes and factory IP address
    // ------------------------------------------------------------
    localparam logic [7:0] ERR_NONE = 8'h00;
    localparam logic [7:0] ERR_WRITE_PROT = 8'h21;
    localparam logic [7:0] ERR_NOT_STARTED = 8'h22;
    localparam logic [31:0] FACTORY_IP = 32'h00000000;

endpackage

// >>> rtl/sscfg_top.sv
// Strap startup loader: samples both switch banks once after reset and
// gates port protocol, baud, port one flow control, network start and EEPROM writes.
// Assumes switches are asynchronous pins; host commands are on clk.
`timescale 1ns/1ps
`default_nettype none
module sscfg_top
    import sscfg_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Switch pins, 1 = closed
    input wire logic [7:0] port_one_switch_bank,
    input wire logic [7:0] port_two_switch_bank,
    // Host protocol choice for controller mode
    input wire logic [1:0] host_proto_sel,
    // Port one transmit gate
    input wire logic cts,
    input wire logic tx1_req,
    output logic tx1_go,
    // Incoming message class per port
    input wire logic [1:0] msg_valid,
    input wire logic [1:0] msg_is_module,
    input wire logic [1:0] msg_is_strict,
    output logic [1:0] msg_accept,
    output logic [1:0] msg_reject,
    // Loopback character stream per port
    output logic [1:0] loop_tx_valid,
    output logic [7:0] loop_char [2],
    // Network control
    input wire logic start_cmd,
    input wire logic start_params_ok,
    input wire logic net_cmd,
    output logic net_cmd_ok,
    output logic server_run,
    output logic server_from_eeprom,
    output logic netcfg_req,
    // EEPROM parameter write
    input wire logic ee_wr,
    input wire logic [31:0] ee_wr_ip,
    output logic ee_wr_done,
    output logic [7:0] ee_err,
    output logic [31:0] ee_ip,
    // Latched configuration
    output sscfg_port_s cfg_port [2],
    output logic cfg_autostart,
    output logic cfg_wprot,
    output logic cfg_error,
    output logic cfg_ready
);

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    function automatic sscfg_port_s decode_bank(input logic [7:0] sw, input logic flow);
        sscfg_port_s p;
        logic [2:0] pr;
        p = '0;
        pr = sw[SW_PROTO_MSB:SW_PROTO_LSB];
        p.baud = sw[SW_BAUD_MSB:SW_BAUD_LSB];
        p.flow_en = flow;
        unique case (pr)
            PROTO_SW_COMBINED: p.proto = SSCFG_PR_COMBINED;
            PROTO_SW_STRICT: p.proto = SSCFG_PR_STRICT;
            PROTO_SW_LOOP: p.proto = SSCFG_PR_LOOP;
            PROTO_SW_CTRL: p.proto = SSCFG_PR_CTRL;
            default:
            begin
                p.proto = SSCFG_PR_COMBINED;
                p.bad = 1'b1;
            end
        endcase
        if (p.baud > BAUD_SW_MAX)
        begin
            p.bad = 1'b1;
        end
        return p;
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [15:0] sw_meta_q;
    logic [15:0] sw_sync_q;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sw_meta_q <= 16'h0000;
            sw_sync_q <= 16'h0000;
        end
        else
        begin
            sw_meta_q <= {port_two_switch_bank, port_one_switch_bank};
            sw_sync_q <= sw_meta_q;
        end
    end

    logic [1:0] cts_meta_q;
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cts_meta_q <= 2'h0;
        end
        else
        begin
            cts_meta_q <= {cts_meta_q[0], cts};
        end
    end

    // ------------------------------------------------------------
    // Startup sequencer
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SSCFG_ST_WAIT = 3'h1,
        SSCFG_ST_SAMPLE = 3'h2,
        SSCFG_ST_HOLD = 3'h4
    } sscfg_state_e;

    sscfg_state_e st_q;
    logic [7:0] cnt_q;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_q <= SSCFG_ST_WAIT;
            cnt_q <= 8'h00;
        end
        else
        begin
            unique case (st_q)
                SSCFG_ST_WAIT:
                begin
                    cnt_q <= cnt_q + 8'h01;
                    if (cnt_q == 8'(SAMPLE_CYC - 1))
                    begin
                        st_q <= SSCFG_ST_SAMPLE;
                    end
                end
                SSCFG_ST_SAMPLE:
                begin
                    st_q <= SSCFG_ST_HOLD;
                    cnt_q <= 8'h00;
                end
                SSCFG_ST_HOLD:
                begin
                    if (cnt_q != 8'(NETCFG_CYC))
                    begin
                        cnt_q <= cnt_q + 8'h01;
                    end
                end
                default:
                begin
                    st_q <= SSCFG_ST_WAIT;
                end
            endcase
        end
    end

    sscfg_port_s bank_dec [2];
    assign bank_dec[0] = decode_bank(sw_sync_q[7:0], sw_sync_q[SW_FLOW_BIT]);
    assign bank_dec[1] = decode_bank(sw_sync_q[15:8], 1'b0);
    // Single capture of both banks, held until reset
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cfg_port[0] <= '0;
            cfg_port[1] <= '0;
            cfg_autostart <= 1'b0;
            cfg_wprot <= 1'b0;
            cfg_error <= 1'b0;
        end
        else if (st_q == SSCFG_ST_SAMPLE)
        begin
            cfg_port[0] <= bank_dec[0];
            cfg_port[1] <= bank_dec[1];
            cfg_autostart <= sw_sync_q[8 + SW_NET_BIT];
            cfg_wprot <= sw_sync_q[8 + SW_PROT_BIT];
            cfg_error <= bank_dec[0].bad | bank_dec[1].bad;
        end
    end

    assign cfg_ready = (st_q == SSCFG_ST_HOLD);

    // ------------------------------------------------------------
    // Port message gating and loopback
    // ------------------------------------------------------------
    sscfg_proto_e eff_proto [2];
    always_comb
    begin
        for (int i = 0; i < 2; i++)
        begin
            eff_proto[i] = (cfg_port[i].proto == SSCFG_PR_CTRL) ?
                sscfg_proto_e'(host_proto_sel) : cfg_port[i].proto;
            msg_accept[i] = 1'b0;
            msg_reject[i] = 1'b0;
            if (cfg_ready && msg_valid[i])
            begin
                unique case (eff_proto[i])
                    SSCFG_PR_COMBINED: msg_accept[i] = 1'b1;
                    SSCFG_PR_STRICT:
                    begin
                        msg_accept[i] = msg_is_strict[i];
                        msg_reject[i] = !msg_is_strict[i];
                    end
                    SSCFG_PR_LOOP: msg_reject[i] = 1'b1;
                    SSCFG_PR_CTRL: msg_accept[i] = msg_is_module[i] | msg_is_strict[i];
                endcase
            end
        end
    end

    // Printable ASCII ramp for loopback plug
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            loop_char[0] <= 8'h20;
            loop_char[1] <= 8'h20;
            loop_tx_valid <= 2'h0;
        end
        else
        begin
            for (int i = 0; i < 2; i++)
            begin
                loop_tx_valid[i] <= cfg_ready && (eff_proto[i] == SSCFG_PR_LOOP);
                if (loop_tx_valid[i])
                begin
                    loop_char[i] <= (loop_char[i] == 8'h7E) ? 8'h20 : loop_char[i] + 8'h01;
                end
            end
        end
    end

    // Port one hardware handshake
    assign tx1_go = tx1_req && cfg_ready && (!cfg_port[0].flow_en || cts_meta_q[1]);

    // ------------------------------------------------------------
    // Network server start
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            server_run <= 1'b0;
            server_from_eeprom <= 1'b0;
            netcfg_req <= 1'b0;
        end
        else if (cfg_ready && !server_run)
        begin
            if (cnt_q == 8'(NETCFG_CYC))
            begin
                netcfg_req <= 1'b1;
            end
            if (cfg_autostart)
            begin
                server_run <= 1'b1;
                server_from_eeprom <= 1'b1;
                netcfg_req <= 1'b0;
            end
            else if (start_cmd && start_params_ok)
            begin
                server_run <= 1'b1;
                netcfg_req <= 1'b0;
            end
        end
    end

    assign net_cmd_ok = net_cmd && server_run;

    // ------------------------------------------------------------
    // EEPROM parameter store
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ee_ip <= FACTORY_IP;
            ee_err <= ERR_NONE;
            ee_wr_done <= 1'b0;
        end
        else
        begin
            ee_wr_done <= ee_wr && cfg_ready;
            if (ee_wr && cfg_ready)
            begin
                if (cfg_wprot)
                begin
                    ee_err <= ERR_WRITE_PROT;
                end
                else
                begin
                    ee_ip <= ee_wr_ip;
                    ee_err <= ERR_NONE;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    cfg_stays_fixed_a: assert property (cfg_ready |=> $stable({cfg_wprot,cfg_autostart}))
        else $error("config changed after sample");
    sample_once_a: assert property (st_q == SSCFG_ST_SAMPLE |=>
        st_q == SSCFG_ST_HOLD [*3])
        else $error("sample repeated");
    wprot_refuse_a: assert property (ee_wr && cfg_ready && cfg_wprot |=>
        $stable(ee_ip) && ee_err == ERR_WRITE_PROT)
        else $error("protected write accepted");
    wr_ok_a: assert property (ee_wr && cfg_ready && !cfg_wprot |=>
        ee_ip == $past(ee_wr_ip))
        else $error("write not stored");
    cts_gate_a: assert property (tx1_go && cfg_port[0].flow_en |-> $past(cts, 2))
        else $error("sent without cts");
    net_block_a: assert property (!server_run |-> !net_cmd_ok)
        else $error("net command before start");
    autostart_a: assert property (cfg_autostart |=> server_run && server_from_eeprom)
        else $error("autostart missing");
    plc_wait_a: assert property (cfg_ready && !cfg_autostart && !server_run &&
        !start_cmd |=> !server_run)
        else $error("started without command");
    strict_rej_a: assert property (cfg_ready && msg_valid[0] &&
        eff_proto[0] == SSCFG_PR_STRICT && !msg_is_strict[0] |-> msg_reject[0])
        else $error("strict mode accepted bad message");
    netcfg_up_a: assert property (cfg_ready && !server_run && cnt_q == 8'(NETCFG_CYC) &&
        !cfg_autostart && !start_cmd |=> netcfg_req)
        else $error("netcfg flag missing");

    start_cmd_c: cover property (start_cmd && start_params_ok && !server_run && cfg_ready);
    prot_wr_c: cover property (ee_wr && cfg_wprot && cfg_ready);
    loop_run_c: cover property (loop_tx_valid[0] [*3]);
    cts_hold_c: cover property (tx1_req && cfg_port[0].flow_en && !tx1_go);

endmodule
`default_nettype wire

// >>> sim/sscfg_host_model.sv
// Model of the host controller and the terminal on port one.
// Assumes the bench sets can_accept and calls put_params.
`timescale 1ns/1ps
`default_nettype none
module sscfg_host_model
    import sscfg_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Terminal flow state
    input wire logic can_accept,
    output logic cts,
    // EEPROM parameter write
    input wire logic ee_wr_done,
    output logic ee_wr,
    output logic [31:0] ee_wr_ip
);
    // ------------------------------------------------------------
    // Terminal handshake
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            cts <= 1'b0;
        else
            cts <= can_accept;
    end

    initial
    begin
        ee_wr = 1'b0;
        ee_wr_ip = 32'h0;
    end

    // ------------------------------------------------------------
    // Parameter store, one write then up to 4 polls of ee_wr_done
    // ------------------------------------------------------------
    task automatic put_params(input logic [31:0] ip, output logic done);
        int n;
        begin
            done = 1'b0;
            @(posedge clk);
            ee_wr <= 1'b1;
            ee_wr_ip <= ip;
            @(posedge clk);
            ee_wr <= 1'b0;
            ee_wr_ip <= ~ip;
            for (n = 0; n < 4 && done !== 1'b1; n++)
            begin
                @(negedge clk);
                done = ee_wr_done;
            end
        end
    endtask
endmodule
`default_nettype wire

// >>> sim/sscfg_top_tb.sv
// Self-checking bench for the startup loader.
// Assumes the host model on the EEPROM and handshake side.
`timescale 1ns/1ps
`default_nettype none
module sscfg_top_tb
    import sscfg_pkg::*;
;
    logic clk, rst_b, cts, tx1_req, tx1_go, start_cmd, start_params_ok, net_cmd, net_cmd_ok;
    logic [7:0] port_one_switch_bank, port_two_switch_bank, ee_err, c0;
    logic [1:0] host_proto_sel, msg_valid, msg_is_module, msg_is_strict;
    logic [1:0] msg_accept, msg_reject, loop_tx_valid;
    logic [7:0] loop_char [2];
    logic server_run, server_from_eeprom, netcfg_req, ee_wr, ee_wr_done, can_accept, ok;
    logic [31:0] ee_wr_ip, ee_ip;
    sscfg_port_s cfg_port [2];
    logic cfg_autostart, cfg_wprot, cfg_error, cfg_ready;
    logic [2:0] codes [5] = '{PROTO_SW_COMBINED, PROTO_SW_STRICT, PROTO_SW_LOOP,
        PROTO_SW_CTRL, 3'h3};
    int n_mismatch, cmp_count;

    sscfg_top sscfg_top_inst (.clk(clk), .rst_b(rst_b),
        .port_one_switch_bank(port_one_switch_bank), .port_two_switch_bank(port_two_switch_bank),
        .host_proto_sel(host_proto_sel), .cts(cts), .tx1_req(tx1_req), .tx1_go(tx1_go),
        .msg_valid(msg_valid), .msg_is_module(msg_is_module), .msg_is_strict(msg_is_strict),
        .msg_accept(msg_accept), .msg_reject(msg_reject), .loop_tx_valid(loop_tx_valid),
        .loop_char(loop_char), .start_cmd(start_cmd), .start_params_ok(start_params_ok),
        .net_cmd(net_cmd), .net_cmd_ok(net_cmd_ok), .server_run(server_run),
        .server_from_eeprom(server_from_eeprom), .netcfg_req(netcfg_req), .ee_wr(ee_wr),
        .ee_wr_ip(ee_wr_ip), .ee_wr_done(ee_wr_done), .ee_err(ee_err), .ee_ip(ee_ip),
        .cfg_port(cfg_port), .cfg_autostart(cfg_autostart), .cfg_wprot(cfg_wprot),
        .cfg_error(cfg_error), .cfg_ready(cfg_ready));

    sscfg_host_model sscfg_host_model_inst (.clk(clk), .rst_b(rst_b), .can_accept(can_accept),
        .cts(cts), .ee_wr_done(ee_wr_done), .ee_wr(ee_wr), .ee_wr_ip(ee_wr_ip));

    // ------------------------------------------------------------
    // Clock and helpers
    // ------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic good, input string what);
        cmp_count++;
        if (good !== 1'b1)
        begin
            n_mismatch++;
            $display("[ERR] %0t %s", $time, what);
        end
    endtask

    function automatic logic pick(input int sel);
        case (sel)
            0: return cfg_ready;
            1: return netcfg_req;
            2: return server_run;
            default: return tx1_go;
        endcase
    endfunction

    task automatic wait_on(input int sel, input int lim);
        int n;
        begin
            for (n = 0; n < lim && pick(sel) !== 1'b1; n++)
                @(negedge clk);
            if (n >= lim)
            begin
                chk(1'b0, "wait ran out");
                report_and_stop();
            end
        end
    endtask

    task automatic boot(input logic [7:0] b1, input logic [7:0] b2);
        @(posedge clk);
        rst_b <= 1'b0;
        port_one_switch_bank <= b1;
        port_two_switch_bank <= b2;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        @(negedge clk);
        wait_on(0, 200);
    endtask

    task automatic send_msg(input logic [1:0] m, input logic [1:0] s, input logic [1:0] acc);
        @(posedge clk);
        msg_valid <= 2'h3;
        msg_is_module <= m;
        msg_is_strict <= s;
        @(negedge clk);
        chk(msg_accept === acc && msg_reject === ~acc, "message class");
    endtask

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial
    begin
        {rst_b, port_one_switch_bank, port_two_switch_bank, host_proto_sel} = 19'h0;
        {tx1_req, msg_valid, msg_is_module, msg_is_strict, can_accept} = 8'h0;
        {start_cmd, start_params_ok, net_cmd} = 3'h0;
        n_mismatch = 0;
        cmp_count = 0;
        boot(8'h00, 8'h00);
        chk({cfg_port[0], cfg_port[1], cfg_autostart, cfg_wprot, cfg_error} === 17'h0, "dflt");
        chk(ee_ip === FACTORY_IP, "factory address");
        @(posedge clk);
        port_one_switch_bank <= 8'hFF;
        port_two_switch_bank <= 8'hFF;
        repeat (5) @(posedge clk);
        @(negedge clk);
        chk({cfg_port[0], cfg_port[1], cfg_autostart, cfg_wprot} === 16'h0, "held");
        send_msg(2'h3, 2'h0, 2'h3);
        send_msg(2'h0, 2'h3, 2'h3);
        @(posedge clk);
        tx1_req <= 1'b1;
        net_cmd <= 1'b1;
        start_cmd <= 1'b1;
        @(negedge clk);
        chk(tx1_go === 1'b1 && net_cmd_ok === 1'b0, "gate before start");
        repeat (3) @(posedge clk);
        start_cmd <= 1'b0;
        @(negedge clk);
        chk(server_run === 1'b0, "start without params");
        wait_on(1, 200);
        sscfg_host_model_inst.put_params(32'h0A000001, ok);
        chk(ok === 1'b1 && ee_err === ERR_NONE && ee_ip === 32'h0A000001, "ee write");
        @(posedge clk);
        start_cmd <= 1'b1;
        start_params_ok <= 1'b1;
        @(posedge clk);
        {start_cmd, start_params_ok} <= 2'h0;
        wait_on(2, 3);
        repeat (2) @(negedge clk);
        chk(server_from_eeprom === 1'b0 && net_cmd_ok === 1'b1, "started");
        chk(netcfg_req === 1'b0, "net cfg cleared");
        @(posedge clk);
        {net_cmd, tx1_req} <= 2'h0;
        $display("test defaults done");

        for (int i = 0; i < 5; i++)
        begin
            boot({codes[i], 5'h03}, {codes[i], 5'h05});
            chk(cfg_error === (i == 4) && cfg_port[0].bad === (i == 4), "bad code");
            chk(cfg_port[0].baud === 3'h3 && cfg_port[1].baud === BAUD_SW_MAX, "baud");
            if (i < 4)
                chk(cfg_port[0].proto === 2'(i) && cfg_port[1].proto === 2'(i), "proto");
            if (i == 1)
                send_msg(2'h3, 2'h0, 2'h0);
            if (i == 2)
            begin
                c0 = loop_char[0];
                repeat (2) @(negedge clk);
                chk(loop_tx_valid === 2'h3 && loop_char[0] !== c0, "loop runs");
                chk(loop_char[1] >= 8'h20 && loop_char[1] <= 8'h7E, "loop char");
            end
            if (i == 3)
            begin
                @(posedge clk);
                host_proto_sel <= 2'h1;
                send_msg(2'h3, 2'h0, 2'h0);
                @(posedge clk);
                host_proto_sel <= 2'h0;
                send_msg(2'h3, 2'h0, 2'h3);
            end
            @(posedge clk);
            msg_valid <= 2'h0;
        end
        $display("test protocols done");

        boot(8'h08, 8'h08);
        chk(cfg_port[0].flow_en === 1'b1 && cfg_port[1].flow_en === 1'b0, "flow");
        @(posedge clk);
        tx1_req <= 1'b1;
        repeat (4) @(negedge clk);
        chk(tx1_go === 1'b0, "held off");
        @(posedge clk);
        can_accept <= 1'b1;
        wait_on(3, 6);
        @(posedge clk);
        tx1_req <= 1'b0;
        $display("test flow done");

        boot(8'h00, 8'h18);
        chk(cfg_autostart === 1'b1 && cfg_wprot === 1'b1, "net switches");
        wait_on(2, 300);
        chk(server_from_eeprom === 1'b1, "autostart source");
        sscfg_host_model_inst.put_params(32'h0A000002, ok);
        chk(ok === 1'b1 && ee_err === ERR_WRITE_PROT, "refused");
        chk(ee_ip === FACTORY_IP, "ee unchanged");
        $display("test autostart done");
        report_and_stop();
    end
endmodule
`default_nettype wire
